// [core/dsms_map.svh]
`ifndef DSMS_MAP_SVH
`define DSMS_MAP_SVH
`define DSMS_REG_PID_FB       16'h0038
`define DSMS_REG_PID_IN       16'h0039
`define DSMS_REG_PID_OUT      16'h003A
`define DSMS_REG_LINK_ERR     16'h003D
`define DSMS_REG_STORE_CMD    16'h0900
`define DSMS_ERR_CRC_BIT      0
`define DSMS_ERR_LEN_BIT      1
`define DSMS_ERR_PAR_BIT      3
`define DSMS_ERR_OVR_BIT      4
`define DSMS_ERR_FRM_BIT      5
`define DSMS_ERR_TMO_BIT      6
`define DSMS_ERR_USED_MASK    8'h7B
`define DSMS_EXC_NONE         8'h00
`define DSMS_EXC_BAD_REG      8'h02
`define DSMS_EXC_WRITE_MODE   8'h22
`define DSMS_PARAM_ADDR_W     6
`define DSMS_PARAM_DEPTH      64
`define DSMS_SEL_RESET        1'b0
`endif

// [core/dsms_pkg.sv]
`default_nettype none
package dsms_pkg;
  typedef enum logic [1:0] {
    DSMS_IDLE  = 2'b00,
    DSMS_COPY  = 2'b01,
    DSMS_DONE  = 2'b11
  } dsms_state_e;

  // one register-access request from the serial protocol engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dsms_req_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  exc;
    logic [15:0] rdata;
  } dsms_rsp_s;

  // raw error events from the receiver, one pulse per detected fault
  typedef struct packed {
    logic crc;
    logic length;
    logic parity;
    logic overrun;
    logic framing;
    logic timeover;
  } dsms_err_s;
endpackage
`default_nettype wire

// [core/dsms_nv_copier.sv]
`include "dsms_map.svh"
`default_nettype none
module dsms_nv_copier
  import dsms_pkg::*;
(
  input  wire logic                          core_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          start_i,
  output logic                               busy_o,
  output logic                               done_o,
  output logic [`DSMS_PARAM_ADDR_W-1:0]      idx_o,
  output logic                               nv_we_o
);
  typedef struct packed {
    dsms_state_e                      st;
    logic [`DSMS_PARAM_ADDR_W-1:0]    idx;
  } dsms_cp_s;

  dsms_cp_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      DSMS_IDLE: begin
        if (start_i) begin
          s_d.st  = DSMS_COPY;
          s_d.idx = '0;
        end
      end
      DSMS_COPY: begin
        // walk every entry so the whole working set lands in storage
        if (s_q.idx == `DSMS_PARAM_ADDR_W'(`DSMS_PARAM_DEPTH - 1)) begin
          s_d.st = DSMS_DONE;
        end else begin
          s_d.idx = s_q.idx + `DSMS_PARAM_ADDR_W'(1);
        end
      end
      DSMS_DONE: s_d.st = DSMS_IDLE;
      default:   s_d.st = DSMS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{st: DSMS_IDLE, idx: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o  = (s_q.st != DSMS_IDLE);
  assign done_o  = (s_q.st == DSMS_DONE);
  assign idx_o   = s_q.idx;
  assign nv_we_o = (s_q.st == DSMS_COPY);

  chk_copy_length: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (s_q.st == DSMS_IDLE && start_i) |=> nv_we_o [*8])
    else $error("copy did not run over consecutive entries");
  // the copy must end on the last entry, one edge per entry plus done
  chk_copy_span: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    (s_q.st == DSMS_IDLE && start_i) |-> ##65 (done_o &&
      idx_o == `DSMS_PARAM_ADDR_W'(`DSMS_PARAM_DEPTH - 1)))
    else $error("copy did not cover the whole parameter set");
endmodule
`default_nettype wire

// [core/dsms_regs.sv]
`include "dsms_map.svh"
`default_nettype none
// What this block does
// - PID in/out signed, 0.1 percent of max frequency; feedback unsigned.
// - each link error flag stays latched until fault reset.
// - fault reset clears link errors even while running.
// - serial parameter writes go to working RAM, and also to the effective copy with selection 1.
// - an accepted write to the store register starts a store, any value.
// - store copies the whole working parameter set to non-volatile memory.
// - store-accept selection is 0 or 1, default 0.
// - selection 0 accepts store only while stopped.
// - selection 1 accepts store while running too, but not under undervoltage or during a copy.
// - selection 1 makes written parameters effective at once.
// - unstored parameters revert to stored values on power-up.
// - store register is write-only; reading it gives exception 02H.
// - keypad changes are committed to non-volatile memory directly.
// - store refused with exception 22H when not accepted, e.g. running.
// - store refused under main undervoltage with exception 22H.
module dsms_regs
  import dsms_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rstn_i,
  input  wire dsms_pkg::dsms_req_s          req_i,
  output dsms_pkg::dsms_rsp_s               rsp_o,
  input  wire dsms_pkg::dsms_err_s          err_i,
  input  wire logic                         fault_reset_i,
  input  wire logic                         running_i,
  input  wire logic                         main_undervoltage_condition_i,
  input  wire logic                         store_accept_select_i,
  input  wire logic                         power_up_i,
  input  wire logic [15:0]                  pid_feedback_i,
  input  wire logic signed [15:0]           pid_input_i,
  input  wire logic signed [15:0]           pid_output_i,
  input  wire logic                         param_we_i,
  input  wire logic [`DSMS_PARAM_ADDR_W-1:0] param_addr_i,
  input  wire logic [15:0]                  param_wdata_i,
  input  wire logic                         keypad_we_i,
  input  wire logic [`DSMS_PARAM_ADDR_W-1:0] keypad_addr_i,
  input  wire logic [15:0]                  keypad_wdata_i,
  input  wire logic [`DSMS_PARAM_ADDR_W-1:0] active_addr_i,
  output logic [15:0]                       active_data_o,
  output logic                              store_busy_o
);
  typedef struct packed {
    logic [7:0]  err;
    dsms_rsp_s   rsp;
    logic        sel;
    logic        init;
    logic [`DSMS_PARAM_ADDR_W-1:0] init_idx;
  } dsms_st_s;

  dsms_st_s s_q, s_d;

  // working RAM, the stored image, and an effective copy used by the drive
  logic [15:0] work_mem [`DSMS_PARAM_DEPTH];
  logic [15:0] nv_mem   [`DSMS_PARAM_DEPTH];
  logic [15:0] eff_mem  [`DSMS_PARAM_DEPTH];

  logic                          cp_start;
  logic                          cp_busy;
  logic                          cp_we;
  logic [`DSMS_PARAM_ADDR_W-1:0] cp_idx;
  logic                          store_wr;
  logic                          store_ok;
  logic [7:0]                    err_set;

  assign store_wr = req_i.valid && req_i.write &&
                    req_i.addr == `DSMS_REG_STORE_CMD;
  // a second store during a copy is refused rather than queued
  assign store_ok = !main_undervoltage_condition_i && !cp_busy &&
                    (s_q.sel || !running_i);
  assign cp_start = store_wr && store_ok;

  always_comb begin
    err_set = 8'h00;
    err_set[`DSMS_ERR_CRC_BIT] = err_i.crc;
    err_set[`DSMS_ERR_LEN_BIT] = err_i.length;
    err_set[`DSMS_ERR_PAR_BIT] = err_i.parity;
    err_set[`DSMS_ERR_OVR_BIT] = err_i.overrun;
    err_set[`DSMS_ERR_FRM_BIT] = err_i.framing;
    err_set[`DSMS_ERR_TMO_BIT] = err_i.timeover;
  end

  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    // reset works regardless of run state; a new event wins over it
    if (fault_reset_i) begin
      s_d.err = 8'h00;
    end
    s_d.err = (s_d.err | err_set) & `DSMS_ERR_USED_MASK;
    s_d.sel = store_accept_select_i;
    if (s_q.init) begin
      s_d.init_idx = s_q.init_idx + `DSMS_PARAM_ADDR_W'(1);
      if (s_q.init_idx == `DSMS_PARAM_ADDR_W'(`DSMS_PARAM_DEPTH - 1)) begin
        s_d.init = 1'b0;
      end
    end
    if (power_up_i) begin
      s_d.init     = 1'b1;
      s_d.init_idx = '0;
    end
    if (req_i.valid) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.exc   = `DSMS_EXC_NONE;
      s_d.rsp.rdata = 16'h0000;
      if (req_i.write) begin
        if (store_wr && !store_ok) begin
          s_d.rsp.exc = `DSMS_EXC_WRITE_MODE;
        end
      end else begin
        unique case (req_i.addr)
          `DSMS_REG_PID_FB:   s_d.rsp.rdata = pid_feedback_i;
          `DSMS_REG_PID_IN:   s_d.rsp.rdata = pid_input_i;
          `DSMS_REG_PID_OUT:  s_d.rsp.rdata = pid_output_i;
          `DSMS_REG_LINK_ERR: s_d.rsp.rdata = {8'h00, s_q.err};
          `DSMS_REG_STORE_CMD: s_d.rsp.exc = `DSMS_EXC_BAD_REG;
          default:            s_d.rsp.exc = `DSMS_EXC_BAD_REG;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{err: 8'h00,
               rsp: '{valid: 1'b0, exc: 8'h00, rdata: 16'h0000},
               sel: `DSMS_SEL_RESET, init: 1'b0, init_idx: '0};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (s_q.init) begin
      // power-up reload drops anything that was never stored
      work_mem[s_q.init_idx] <= nv_mem[s_q.init_idx];
      eff_mem[s_q.init_idx]  <= nv_mem[s_q.init_idx];
    end else begin
      // copy goes first, so a keypad edit, or a serial edit with selection 1, of the same entry in that cycle wins
      if (cp_we) begin
        eff_mem[cp_idx] <= work_mem[cp_idx];
      end
      if (keypad_we_i) begin
        work_mem[keypad_addr_i] <= keypad_wdata_i;
        eff_mem[keypad_addr_i]  <= keypad_wdata_i;
      end else if (param_we_i) begin
        work_mem[param_addr_i] <= param_wdata_i;
        if (s_q.sel) begin
          eff_mem[param_addr_i] <= param_wdata_i;
        end
      end
    end
  end

  // keypad writes bypass the store command and hit storage at once;
  // an edit never stops the copy of another entry in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (cp_we) begin
      nv_mem[cp_idx] <= work_mem[cp_idx];
    end
    if (keypad_we_i && !s_q.init) begin
      nv_mem[keypad_addr_i] <= keypad_wdata_i;
    end
  end

  dsms_nv_copier u_copier (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .start_i    (cp_start),
    .busy_o     (cp_busy),
    .done_o     (),
    .idx_o      (cp_idx),
    .nv_we_o    (cp_we)
  );

  assign rsp_o         = s_q.rsp;
  assign active_data_o = eff_mem[active_addr_i];
  assign store_busy_o  = cp_busy;

  default clocking cb_core @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // no flag may drop unless a fault reset was seen at that edge
  chk_err_latched: assert property (
    !fault_reset_i |=> (s_q.err & $past(s_q.err)) == $past(s_q.err))
    else $error("link error flag dropped without fault reset");
  chk_err_reset_run: assert property (
    (fault_reset_i && running_i && err_set == 8'h00) |=> s_q.err == 8'h00)
    else $error("fault reset ignored while running");
  chk_err_unused_zero: assert property (
    (s_q.err & 8'h84) == 8'h00)
    else $error("unused link error bit set");
  chk_store_any_value: assert property (
    (store_wr && !cp_busy && !running_i && !main_undervoltage_condition_i)
      |=> cp_busy)
    else $error("store write did not start copy");
  chk_store_run_sel0: assert property (
    (store_wr && running_i && !s_q.sel) |=>
      rsp_o.exc == `DSMS_EXC_WRITE_MODE)
    else $error("store accepted while running with selection 0");
  chk_store_run_sel1: assert property (
    (store_wr && running_i && s_q.sel && !cp_busy &&
     !main_undervoltage_condition_i) |=> rsp_o.exc == `DSMS_EXC_NONE)
    else $error("store refused while running with selection 1");
  chk_store_busy_refused: assert property (
    (store_wr && cp_busy) |=> rsp_o.valid &&
      rsp_o.exc == `DSMS_EXC_WRITE_MODE)
    else $error("store accepted while a copy was running");
  chk_store_uv_refused: assert property (
    (store_wr && main_undervoltage_condition_i) |=> !$rose(cp_busy) &&
      rsp_o.exc == `DSMS_EXC_WRITE_MODE)
    else $error("store accepted under undervoltage");
  chk_store_read_bad: assert property (
    (req_i.valid && !req_i.write && req_i.addr == `DSMS_REG_STORE_CMD)
      |=> rsp_o.valid && rsp_o.exc == `DSMS_EXC_BAD_REG)
    else $error("store register read not refused");
  chk_pid_fb_read: assert property (
    (req_i.valid && !req_i.write && req_i.addr == `DSMS_REG_PID_FB)
      |=> rsp_o.rdata == $past(pid_feedback_i))
    else $error("feedback monitor value wrong");

  cov_store_run: cover property (cp_start && running_i);
  cov_store_refused: cover property (store_wr && !store_ok);
  cov_err_clear: cover property (s_q.err != 8'h00 ##1 s_q.err == 8'h00);
  cov_power_up: cover property ($fell(s_q.init));
endmodule
`default_nettype wire

// [test/dsms_plc_model.sv]
`default_nettype none
module dsms_plc_model
  import dsms_pkg::*;
(
  input  wire logic                core_clk_i,
  output dsms_pkg::dsms_req_s      req_o,
  input  wire dsms_pkg::dsms_rsp_s rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // one request per call, so store commands go out only when asked
  task automatic access(input logic w, input logic [15:0] a, d,
                        output logic [7:0] exc, output logic [15:0] rd,
                        output logic ok);
    @(posedge core_clk_i);
    req_o <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge core_clk_i);
    // released lines show the inverse so stale values cannot pass
    req_o <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    #1;
    ok = rsp_i.valid;
    exc = rsp_i.exc;
    rd = rsp_i.rdata;
  endtask
endmodule
`default_nettype wire

// [test/dsms_regs_tb.sv]
`include "dsms_map.svh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module dsms_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsms_pkg::*;
  logic                          core_clk_i = 1'b0;
  logic                          rstn_i = 1'b0;
  dsms_req_s                     req;
  dsms_rsp_s                     rsp;
  dsms_err_s                     err = '0;
  logic                          frst = '0, run = '0, uv = '0, sel = '0;
  logic                          pwr = '0, pwe = '0, kwe = '0, busy, ok;
  logic [15:0]                   pfb = '0, pwd = '0, kwd = '0, act_d, rd;
  logic signed [15:0]            pin = '0, pout = '0;
  logic [`DSMS_PARAM_ADDR_W-1:0] pa = '0, ka = '0, act_a = '0;
  logic [7:0]                    exc;
  int                            err_count = 0;
  int                            num_checks = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  dsms_plc_model plc_u (.core_clk_i(core_clk_i), .req_o(req), .rsp_i(rsp));
  dsms_regs dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req),
    .rsp_o(rsp), .err_i(err), .fault_reset_i(frst), .running_i(run),
    .main_undervoltage_condition_i(uv), .store_accept_select_i(sel),
    .power_up_i(pwr), .pid_feedback_i(pfb), .pid_input_i(pin),
    .pid_output_i(pout), .param_we_i(pwe), .param_addr_i(pa),
    .param_wdata_i(pwd), .keypad_we_i(kwe), .keypad_addr_i(ka),
    .keypad_wdata_i(kwd), .active_addr_i(act_a), .active_data_o(act_d),
    .store_busy_o(busy));

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e,
                        input logic [15:0] d);
    plc_u.access(1'b0, a, 16'h0000, exc, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(exc, e)
    `CHK(rd, d)
  endtask

  task automatic wr_reg(input logic [15:0] a, d, input logic [7:0] e);
    plc_u.access(1'b1, a, d, exc, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(exc, e)
  endtask

  task automatic set_par(input logic k, input logic [5:0] a,
                         input logic [15:0] d);
    @(posedge core_clk_i);
    if (k) begin
      kwe <= 1; ka <= a; kwd <= d;
    end else begin
      pwe <= 1; pa <= a; pwd <= d;
    end
    @(posedge core_clk_i);
    kwe <= 0;
    pwe <= 0;
  endtask

  task automatic chk_act(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    act_a <= a;
    @(posedge core_clk_i);
    #1;
    `CHK(act_d, d)
  endtask

  task automatic power_cycle();
    @(posedge core_clk_i);
    pwr <= 1;
    @(posedge core_clk_i);
    pwr <= 0;
    repeat (66) @(posedge core_clk_i);
  endtask

  // a copy that never ends would hang the run, so the wait is capped
  task automatic wait_idle();
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge core_clk_i);
    if (busy !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic t_mon();
    @(posedge core_clk_i);
    pfb <= 16'hFFF0;
    pin <= 16'shFC18;
    pout <= 16'sh7FFF;
    rd_reg(`DSMS_REG_PID_FB, `DSMS_EXC_NONE, 16'hFFF0);
    rd_reg(`DSMS_REG_PID_IN, `DSMS_EXC_NONE, 16'hFC18);
    rd_reg(`DSMS_REG_PID_OUT, `DSMS_EXC_NONE, 16'h7FFF);
    $display("t_mon done");
  endtask

  task automatic t_err();
    int pos[6] = '{0, 1, 3, 4, 5, 6};
    logic [15:0] e;
    e = 16'h0000;
    for (int b = 0; b < 6; b++) begin
      @(posedge core_clk_i);
      err <= 6'b100000 >> b;
      @(posedge core_clk_i);
      err <= '0;
      e[pos[b]] = 1'b1;
      rd_reg(`DSMS_REG_LINK_ERR, `DSMS_EXC_NONE, e);
    end
    @(posedge core_clk_i);
    run <= 1;
    frst <= 1;
    @(posedge core_clk_i);
    frst <= 0;
    rd_reg(`DSMS_REG_LINK_ERR, `DSMS_EXC_NONE, 16'h0000);
    run <= 0;
    $display("t_err done");
  endtask

  task automatic t_store0();
    rd_reg(`DSMS_REG_STORE_CMD, `DSMS_EXC_BAD_REG, 16'h0000);
    rd_reg(16'h0100, `DSMS_EXC_BAD_REG, 16'h0000);
    set_par(1, 5, 16'h1234);
    set_par(1, 9, 16'h0A0A);
    power_cycle();
    chk_act(5, 16'h1234);
    set_par(0, 5, 16'hABCD);
    chk_act(5, 16'h1234);
    run <= 1;
    wr_reg(`DSMS_REG_STORE_CMD, 0, `DSMS_EXC_WRITE_MODE);
    run <= 0;
    uv <= 1;
    wr_reg(`DSMS_REG_STORE_CMD, 0, `DSMS_EXC_WRITE_MODE);
    uv <= 0;
    wr_reg(`DSMS_REG_STORE_CMD, 16'hFFFF, `DSMS_EXC_NONE);
    `CHK(busy, 1'b1)
    wr_reg(`DSMS_REG_STORE_CMD, 1, `DSMS_EXC_WRITE_MODE);
    wait_idle();
    power_cycle();
    chk_act(5, 16'hABCD);
    chk_act(9, 16'h0A0A);
    $display("t_store0 done");
  endtask

  task automatic t_sel1();
    sel <= 1;
    run <= 1;
    set_par(0, 7, 16'h5555);
    chk_act(7, 16'h5555);
    wr_reg(`DSMS_REG_STORE_CMD, 0, `DSMS_EXC_NONE);
    wait_idle();
    set_par(0, 7, 16'h6666);
    chk_act(7, 16'h6666);
    run <= 0;
    power_cycle();
    chk_act(7, 16'h5555);
    sel <= 0;
    $display("t_sel1 done");
  endtask

  initial begin
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1;
    t_mon();
    t_err();
    t_store0();
    t_sel1();
    test_done();
  end
endmodule
`undef CHK
`default_nettype wire
